//--- src/pcu_top.sv
// programmable checksum unit with an apb slave register port
// assumes a single apb master on pclk; apb4 pstrb gives the write width
//
// Summary of operation
// - One 32-bit data register: writes feed data, reads return the result.
// - Each data write folds word, half or byte into the stored checksum.
// - Data register takes word, low half, low byte; others word only.
// - Word takes four cycles, half-word two, byte one.
// - Input buffer takes a second write at once without wait states.
// - Widths may mix freely between successive writes.
// - Input bits optionally reversed per byte, half-word or whole word.
// - Output reversal flips the read result across the full word.
// - Reset control bit reloads the data register with the initial value.
// - Writing the initial value register also loads it as checksum.
// - 8-bit scratch register, untouched by the calculator reset bit.
// - Polynomial fully programmable; size 7, 8, 16 or 32 bits.
// - Narrow checksums read back in the low bits, in the high bits once output reversal is on.
// - Polynomial resets to the ethernet 32-bit polynomial.
// - Input reversal: 00 none, 01 byte, 10 half-word, 11 word.
// - Size: 00 is 32, 01 is 16, 10 is 8, 11 is 7 bits.
// - Reset bit set by software only, cleared by hardware afterwards.
`timescale 1ns/1ps
module pcu_top (
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // apb request
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [pcu_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    // apb answer
    output logic                            pready,
    output logic      [31:0]                prdata,
    output logic                            pslverr
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [31:0]        crc_q;
    logic [31:0]        init_q;
    logic [31:0]        poly_q;
    logic [7:0]         scratch_q;
    pcu_pkg::pcu_size_t size_q;
    pcu_pkg::pcu_rev_t  revin_q;
    logic               revout_q;
    logic               reset_bit_q;
    logic               buf_valid_q;
    logic [31:0]        buf_data_q;
    logic [2:0]         buf_bytes_q;
    logic [31:0]        eng_data_q;
    logic [2:0]         eng_cnt_q;
    logic [31:0]        prdata_q;
    logic               rd_ok_q;

    logic [31:0] step_out;
    logic        access;
    logic        is_data;
    logic        is_scratch;
    logic        is_control;
    logic        is_init;
    logic        is_poly;
    logic        mapped;
    logic [2:0]  wr_bytes;
    logic        err;
    logic        ready;
    logic        done_wr;
    logic        wr_data;
    logic        flush;
    logic        load;
    logic        busy;
    logic [31:0] rdata;
    logic [31:0] in_aligned;

    // ------------------------------------------------------------------
    // write width from strobes; zero marks an illegal pattern
    // ------------------------------------------------------------------
    function automatic logic [2:0] strb_bytes(input logic [3:0] s);
        if (s == pcu_pkg::STRB_WORD) begin
            strb_bytes = 3'd4;
        end else if (s == pcu_pkg::STRB_HALF) begin
            strb_bytes = 3'd2;
        end else if (s == pcu_pkg::STRB_BYTE) begin
            strb_bytes = 3'd1;
        end else begin
            strb_bytes = 3'd0;
        end
    endfunction

    // ------------------------------------------------------------------
    // decode and handshake
    // ------------------------------------------------------------------
    always_comb begin
        access     = psel & penable;
        is_data    = (paddr == pcu_pkg::OFF_DATA);
        is_scratch = (paddr == pcu_pkg::OFF_SCRATCH);
        is_control = (paddr == pcu_pkg::OFF_CONTROL);
        is_init    = (paddr == pcu_pkg::OFF_INIT);
        is_poly    = (paddr == pcu_pkg::OFF_POLY);
        mapped     = is_data | is_scratch | is_control | is_init | is_poly;
        wr_bytes   = strb_bytes(pstrb);
        err        = !mapped;
        if (pwrite && is_data && wr_bytes == 3'd0) begin
            err = 1'b1;
        end
        if (pwrite && !is_data && pstrb != pcu_pkg::STRB_WORD) begin
            err = 1'b1;
        end
        if (err) begin
            ready = 1'b1;
        end else if (is_data && pwrite) begin
            ready = !buf_valid_q;
        end else if (is_data) begin
            ready = rd_ok_q;
        end else begin
            ready = 1'b1;
        end
        done_wr = access & ready & pwrite & !err;
        wr_data = done_wr & is_data;
    end

    assign pready  = access & ready;
    assign pslverr = access & ready & err;
    assign prdata  = prdata_q;

    // ------------------------------------------------------------------
    // input reversal, narrowed to the written width, then left-aligned
    // ------------------------------------------------------------------
    always_comb begin
        pcu_pkg::pcu_rev_t eff;
        logic [31:0]       r;
        eff = revin_q;
        r   = pwdata;
        if (wr_bytes == 3'd1 && eff != pcu_pkg::PCU_REV_NONE) begin
            eff = pcu_pkg::PCU_REV_BYTE;
        end
        if (wr_bytes == 3'd2 && eff == pcu_pkg::PCU_REV_WORD) begin
            eff = pcu_pkg::PCU_REV_HALF;
        end
        unique case (eff)
            pcu_pkg::PCU_REV_NONE: r = pwdata;
            pcu_pkg::PCU_REV_BYTE: begin
                for (int b = 0; b < 4; b++) begin
                    for (int i = 0; i < 8; i++) begin
                        r[8*b+i] = pwdata[8*b+7-i];
                    end
                end
            end
            pcu_pkg::PCU_REV_HALF: begin
                for (int h = 0; h < 2; h++) begin
                    for (int i = 0; i < 16; i++) begin
                        r[16*h+i] = pwdata[16*h+15-i];
                    end
                end
            end
            pcu_pkg::PCU_REV_WORD: r = pcu_pkg::rev_word(pwdata);
        endcase
        // msb of the written width is processed first
        unique case (wr_bytes)
            3'd1:    in_aligned = {r[7:0], 24'h00_0000};
            3'd2:    in_aligned = {r[15:0], 16'h0000};
            default: in_aligned = r;
        endcase
    end

    // ------------------------------------------------------------------
    // byte engine
    // ------------------------------------------------------------------
    pcu_crc_step u_step (
        .crc_in   (crc_q),
        .byte_in  (eng_data_q[31:24]),
        .poly     (poly_q),
        .size_sel (size_q),
        .crc_out  (step_out)
    );

    // an init write or calculator reset discards queued data
    assign flush = (done_wr & is_init) | reset_bit_q;
    assign load  = buf_valid_q & (eng_cnt_q <= 3'd1) & !flush;
    assign busy  = buf_valid_q | (eng_cnt_q != 3'd0) | reset_bit_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_valid_q <= 1'b0;
            buf_data_q  <= 32'h0000_0000;
            buf_bytes_q <= 3'd0;
        end else if (flush) begin
            buf_valid_q <= 1'b0;
        end else if (wr_data) begin
            buf_valid_q <= 1'b1;
            buf_data_q  <= in_aligned;
            buf_bytes_q <= wr_bytes;
        end else if (load) begin
            buf_valid_q <= 1'b0;
        end
    end

    // one byte per cycle gives 4, 2 and 1 cycles per width
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_data_q <= 32'h0000_0000;
            eng_cnt_q  <= 3'd0;
        end else if (flush) begin
            eng_cnt_q  <= 3'd0;
        end else if (load) begin
            eng_data_q <= buf_data_q;
            eng_cnt_q  <= buf_bytes_q;
        end else if (eng_cnt_q != 3'd0) begin
            eng_data_q <= {eng_data_q[23:0], 8'h00};
            eng_cnt_q  <= eng_cnt_q - 3'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_q <= pcu_pkg::RST_DATA;
        end else if (done_wr && is_init) begin
            crc_q <= pwdata;
        end else if (reset_bit_q) begin
            crc_q <= init_q;
        end else if (eng_cnt_q != 3'd0) begin
            crc_q <= step_out;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_q <= pcu_pkg::RST_INIT;
            poly_q <= pcu_pkg::RST_POLY;
        end else if (done_wr && is_init) begin
            init_q <= pwdata;
        end else if (done_wr && is_poly) begin
            poly_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            size_q   <= pcu_pkg::PCU_SIZE_32;
            revin_q  <= pcu_pkg::PCU_REV_NONE;
            revout_q <= 1'b0;
        end else if (done_wr && is_control) begin
            size_q   <= pcu_pkg::pcu_size_t'(
                        pwdata[pcu_pkg::CR_SIZE_LSB +: 2]);
            revin_q  <= pcu_pkg::pcu_rev_t'(
                        pwdata[pcu_pkg::CR_REVIN_LSB +: 2]);
            revout_q <= pwdata[pcu_pkg::CR_REVOUT_BIT];
        end
    end

    // writing zero has no effect; a new set beats the hardware clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_bit_q <= 1'b0;
        end else if (done_wr && is_control
                     && pwdata[pcu_pkg::CR_RESET_BIT]) begin
            reset_bit_q <= 1'b1;
        end else begin
            reset_bit_q <= 1'b0;
        end
    end

    // not in the flush path, so the calculator reset leaves it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scratch_q <= pcu_pkg::RST_SCRATCH;
        end else if (done_wr && is_scratch) begin
            scratch_q <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // read data, captured every cycle of a transfer
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0] res;
        res = (crc_q << pcu_pkg::size_shift(size_q))
              >> pcu_pkg::size_shift(size_q);
        if (revout_q) begin
            res = pcu_pkg::rev_word(res);
        end
        rdata = 32'h0000_0000;
        if (is_data) begin
            rdata = res;
        end else if (is_scratch) begin
            rdata = {24'h00_0000, scratch_q};
        end else if (is_control) begin
            rdata[pcu_pkg::CR_RESET_BIT]         = reset_bit_q;
            rdata[pcu_pkg::CR_SIZE_LSB +: 2]     = size_q;
            rdata[pcu_pkg::CR_REVIN_LSB +: 2]    = revin_q;
            rdata[pcu_pkg::CR_REVOUT_BIT]        = revout_q;
        end else if (is_init) begin
            rdata = init_q;
        end else if (is_poly) begin
            rdata = poly_q;
        end
    end

    // rd_ok_q says the checksum did not move at the capture edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            rd_ok_q  <= 1'b0;
        end else begin
            if (psel) begin
                prdata_q <= rdata;
            end
            rd_ok_q <= psel & !busy;
        end
    end

endmodule

//--- src/pcu_pkg.sv
// constants for the programmable checksum unit: map, fields, resets
// assumes an apb slave with 32-bit data and a 5-bit byte address
package pcu_pkg;

    // ------------------------------------------------------------------
    // address map (byte addresses)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 5;
    localparam logic [4:0] OFF_DATA    = 5'h00;
    localparam logic [4:0] OFF_SCRATCH = 5'h04;
    localparam logic [4:0] OFF_CONTROL = 5'h08;
    localparam logic [4:0] OFF_INIT    = 5'h10;
    localparam logic [4:0] OFF_POLY    = 5'h14;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int unsigned CR_RESET_BIT = 0;
    localparam int unsigned CR_SIZE_LSB  = 3;
    localparam int unsigned CR_REVIN_LSB = 5;
    localparam int unsigned CR_REVOUT_BIT = 7;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_DATA    = 32'hFFFF_FFFF;
    localparam logic [7:0]  RST_SCRATCH = 8'h00;
    localparam logic [31:0] RST_INIT    = 32'hFFFF_FFFF;
    localparam logic [31:0] RST_POLY    = 32'h04C1_1DB7;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PCU_SIZE_32 = 2'b00,
        PCU_SIZE_16 = 2'b01,
        PCU_SIZE_8  = 2'b10,
        PCU_SIZE_7  = 2'b11
    } pcu_size_t;

    typedef enum logic [1:0] {
        PCU_REV_NONE = 2'b00,
        PCU_REV_BYTE = 2'b01,
        PCU_REV_HALF = 2'b10,
        PCU_REV_WORD = 2'b11
    } pcu_rev_t;

    localparam logic [3:0] STRB_WORD = 4'hF;
    localparam logic [3:0] STRB_HALF = 4'h3;
    localparam logic [3:0] STRB_BYTE = 4'h1;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // left shift that places a w-bit checksum at the top of the word
    function automatic logic [4:0] size_shift(input pcu_size_t s);
        unique case (s)
            PCU_SIZE_32: size_shift = 5'd0;
            PCU_SIZE_16: size_shift = 5'd16;
            PCU_SIZE_8:  size_shift = 5'd24;
            PCU_SIZE_7:  size_shift = 5'd25;
        endcase
    endfunction

    function automatic logic [31:0] rev_word(input logic [31:0] v);
        for (int i = 0; i < 32; i++) begin
            rev_word[i] = v[31-i];
        end
    endfunction

endpackage

//--- src/pcu_crc_step.sv
// one byte of checksum arithmetic, msb first, for any selected width
// assumes the checksum sits in the low bits and upper bits are ignored
`timescale 1ns/1ps
module pcu_crc_step (
    // operands
    input  wire logic [31:0]       crc_in,
    input  wire logic [7:0]        byte_in,
    input  wire logic [31:0]       poly,
    input  wire pcu_pkg::pcu_size_t size_sel,
    // result
    output logic      [31:0]       crc_out
);

    // ------------------------------------------------------------------
    // left-align so one 32-bit loop serves every width
    // ------------------------------------------------------------------
    always_comb begin
        logic [4:0]  sh;
        logic [31:0] c;
        logic [31:0] p;
        logic        fb;
        sh = pcu_pkg::size_shift(size_sel);
        c  = crc_in << sh;
        p  = poly << sh;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            fb = c[31] ^ byte_in[i];
            c  = c << 1;
            if (fb) begin
                c = c ^ p;
            end
        end
        crc_out = c >> sh;
    end

endmodule

//--- verification/pcu_chk.sv
// checker for the apb port of the checksum unit
// assumes it is bound onto pcu_top and sees only its ports
`timescale 1ns/1ps
module pcu_chk (
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // apb request
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [pcu_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    // apb answer
    input  wire logic                       pready,
    input  wire logic [31:0]                prdata,
    input  wire logic                       pslverr
);
    logic acc;
    logic dat;
    logic map;
    logic okw;
    assign acc = psel && penable;
    assign dat = paddr == pcu_pkg::OFF_DATA;
    assign map = paddr inside {pcu_pkg::OFF_DATA, pcu_pkg::OFF_SCRATCH,
        pcu_pkg::OFF_CONTROL, pcu_pkg::OFF_INIT, pcu_pkg::OFF_POLY};
    // narrow strobes are legal on the data register alone
    assign okw = dat ? pstrb inside {4'hF, 4'h3, 4'h1} : pstrb == 4'hF;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------
    // assertions
    // ------------
    a_ready_in_access: assert property (pready |-> acc)
        else $error("pready outside an access phase");
    a_idle_quiet: assert property (!psel |-> !pready && !pslverr)
        else $error("answer while not selected");
    a_reg_no_wait: assert property (acc && !dat |-> pready)
        else $error("register access was stalled");
    a_unmapped_err: assert property (acc && !map |-> pslverr)
        else $error("unmapped access not refused");
    a_strb_err: assert property (
        acc && pwrite && map && !okw |-> pready && pslverr)
        else $error("illegal strobe not refused");
    a_legal_no_err: assert property (
        acc && pready && map && (!pwrite || okw) |-> !pslverr)
        else $error("legal access refused");
    a_write_bound: assert property (
        $rose(penable) && psel && pwrite && dat |-> ##[0:5] pready)
        else $error("data write stalled too long");
    a_read_bound: assert property (
        $rose(penable) && psel && !pwrite && dat |-> ##[0:12] pready)
        else $error("data read stalled too long");
    a_rdata_hold: assert property (!$past(psel) |-> $stable(prdata))
        else $error("read data moved while idle");
    c_write_wait: cover property (acc && pwrite && dat && !pready);
    c_refused: cover property (acc && pready && pslverr);
    c_data_read: cover property (acc && pready && !pwrite && dat);
endmodule

bind pcu_top pcu_chk u_pcu_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr)
);

//--- verification/pcu_apb_bfm.sv
// apb master model standing in for the processor or dma side
// assumes callers enter xfer and park right after a rising pclk edge
`timescale 1ns/1ps
module pcu_apb_bfm (
    // clock and answer
    input  wire logic                       pclk,
    input  wire logic                       pready,
    // apb request
    output logic                            psel,
    output logic                            penable,
    output logic                            pwrite,
    output logic [pcu_pkg::ADDR_W-1:0]      paddr,
    output logic [31:0]                     pwdata,
    output logic [3:0]                      pstrb
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
    end
    // released address and data lines flip so stale values never look valid
    task automatic park(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
        repeat (n) @(posedge pclk);
    endtask
    // request held until the edge that samples pready high
    task automatic xfer(input logic w, input logic [4:0] a,
            input logic [31:0] d, input logic [3:0] s, input int g);
        if (g > 0) park(g);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
    endtask
endmodule

//--- verification/pcu_tb_top.sv
// self-checking bench for the programmable checksum unit
// assumes pcu_top with its checker bound and the apb master model
`timescale 1ns/1ps
module pcu_tb_top;
    typedef struct {
        logic [31:0] d;
        logic        e;
        bit          rd;
        int          w;
    } pcu_note_t;
    logic                       pclk = 1'b0;
    logic                       presetn;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [pcu_pkg::ADDR_W-1:0] paddr;
    logic [31:0]                pwdata;
    logic [3:0]                 pstrb;
    logic                       pready;
    logic [31:0]                prdata;
    logic                       pslverr;
    pcu_note_t                  notes[$];
    pcu_note_t                  n;
    int                         mismatches = 0;
    int                         checks_done = 0;
    int                         waits = 0;
    int                         cycles = 0;
    logic [31:0]                seed = 32'h0000_751B;
    logic [31:0]                crc_m;
    logic [31:0]                init_m;
    logic [31:0]                poly_m;
    logic [31:0]                sc_m;
    logic [7:0]                 ctl_m;
    int                         sh_m;

    always #2.5 pclk = ~pclk;

    pcu_top u_pcu_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr));
    pcu_apb_bfm u_pcu_apb_bfm (.pclk(pclk), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb));

    // ------------
    // reference model
    // ------------
    function automatic logic [31:0] nxt();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [31:0] rv(input logic [31:0] v, input int c);
        for (int i = 0; i < 32; i++) rv[(i / c) * c + c - 1 - i % c] = v[i];
    endfunction
    // checksum kept in the low bits, shifted up for msb-first division
    function automatic logic [31:0] step(input logic [31:0] c,
            input logic [7:0] b);
        logic [31:0] x;
        x = (c << sh_m) ^ {b, 24'h00_0000};
        for (int i = 0; i < 8; i++) x = x[31] ? (x << 1) ^ (poly_m << sh_m)
                                              : x << 1;
        return x >> sh_m;
    endfunction
    function automatic logic [31:0] res();
        logic [31:0] m;
        m = (sh_m == 0) ? crc_m
                        : crc_m & ((32'h0000_0001 << (32 - sh_m)) - 1);
        return ctl_m[7] ? rv(m, 32) : m;
    endfunction

    // ------------
    // stimulus
    // ------------
    task automatic op(input logic w, input logic [4:0] a, input logic [31:0] d,
            input logic [3:0] s, input logic [31:0] x, input logic e,
            input bit r, input int wc, input int g);
        notes.push_back('{x, e, r, wc});
        u_pcu_apb_bfm.xfer(w, a, d, s, g);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] x, input int g);
        op(1'b0, a, 32'h0000_0000, 4'h0, x, 1'b0, 1, 0, g);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        op(1'b1, a, d, pcu_pkg::STRB_WORD, 32'h0000_0000, 1'b0, 0, 0, 0);
    endtask
    task automatic feed(input int nb, input int wc, input int g);
        logic [31:0] d;
        logic [31:0] v;
        int c;
        d = nxt();
        c = (ctl_m[6:5] == 2'b00) ? 0 : 4 << ctl_m[6:5];
        if (c > 8 * nb) c = 8 * nb;
        v = (c == 0) ? d : rv(d, c);
        for (int i = nb - 1; i >= 0; i--) crc_m = step(crc_m, v[8 * i +: 8]);
        op(1'b1, pcu_pkg::OFF_DATA, d, nb == 4 ? pcu_pkg::STRB_WORD :
           nb == 2 ? pcu_pkg::STRB_HALF : pcu_pkg::STRB_BYTE,
           32'h0000_0000, 1'b0, 0, wc, g);
    endtask
    task automatic complete_run();
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(pcu_pkg::OFF_DATA, pcu_pkg::RST_DATA, 0);
        rd(pcu_pkg::OFF_SCRATCH, {24'h00_0000, pcu_pkg::RST_SCRATCH}, 0);
        rd(pcu_pkg::OFF_CONTROL, 32'h0000_0000, 0);
        rd(pcu_pkg::OFF_INIT, pcu_pkg::RST_INIT, 0);
        rd(pcu_pkg::OFF_POLY, pcu_pkg::RST_POLY, 0);
        $display("test reset values done");
        for (int k = 0; k < 16; k++) begin
            poly_m = nxt() | 32'h0000_0001;
            wr(pcu_pkg::OFF_POLY, poly_m);
            rd(pcu_pkg::OFF_POLY, poly_m, 0);
            ctl_m = {seed[9], k[3:2], k[1:0], 3'b000};
            sh_m = (k[1:0] == 0) ? 0 : (k[1:0] == 1) ? 16 : 22 + k[1:0];
            wr(pcu_pkg::OFF_CONTROL, {24'h00_0000, ctl_m});
            init_m = nxt();
            wr(pcu_pkg::OFF_INIT, init_m);
            crc_m = init_m;
            for (int j = 0; j < 5; j++) feed(1 << (nxt() % 3), 0, nxt() % 2);
            rd(pcu_pkg::OFF_DATA, res(), 0);
        end
        $display("test modes and widths done");
        feed(4, 1, 0);
        feed(4, 1, 0);
        feed(4, 2, 0);
        rd(pcu_pkg::OFF_DATA, res(), 0);
        for (int j = 0; j < 3; j++) feed(1, 1, 0);
        rd(pcu_pkg::OFF_DATA, res(), 0);
        $display("test timing done");
        sc_m = nxt() & 32'h0000_00FF;
        wr(pcu_pkg::OFF_SCRATCH, sc_m);
        feed(4, 0, 0);
        wr(pcu_pkg::OFF_CONTROL, {24'h00_0000, ctl_m | 8'h01});
        crc_m = init_m;
        rd(pcu_pkg::OFF_CONTROL, {24'h00_0000, ctl_m}, 2);
        rd(pcu_pkg::OFF_DATA, res(), 0);
        rd(pcu_pkg::OFF_SCRATCH, sc_m, 0);
        $display("test calculator reset done");
        op(1'b0, 5'h0C, 32'h0000_0000, 4'h0, 32'h0, 1'b1, 0, 0, 0);
        op(1'b1, 5'h1C, nxt(), 4'hF, 32'h0, 1'b1, 0, 0, 1);
        op(1'b1, pcu_pkg::OFF_CONTROL, 32'h0000_0001, pcu_pkg::STRB_HALF,
           32'h0, 1'b1, 0, 0, 0);
        op(1'b1, pcu_pkg::OFF_SCRATCH, nxt(), pcu_pkg::STRB_BYTE,
           32'h0, 1'b1, 0, 0, 0);
        op(1'b1, pcu_pkg::OFF_DATA, nxt(), 4'h2, 32'h0, 1'b1, 0, 0, 0);
        rd(pcu_pkg::OFF_CONTROL, {24'h00_0000, ctl_m}, 0);
        rd(pcu_pkg::OFF_SCRATCH, sc_m, 0);
        rd(pcu_pkg::OFF_DATA, res(), 0);
        $display("test refusals done");
        u_pcu_apb_bfm.park(4);
        complete_run();
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end

    // compares each completed transfer with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready !== 1'b1) begin
            waits++;
        end else if (psel && penable) begin
            n = notes.pop_front();
            checks_done++;
            if (pslverr !== n.e || (n.rd && prdata !== n.d) ||
                (n.w == 1 && waits != 0) || (n.w == 2 && waits != 2)) begin
                mismatches++;
                $display("unexpected at %0t: addr %h read %h err %b waits %0d",
                         $time, paddr, prdata, pslverr, waits);
            end
            waits = 0;
        end
    end
endmodule
